// File: logic/gdpc_gpio_config.sv
// Overview of operation
// - Registers answer only in config state, matching index
// - Bank1 direction bits 0-4: 0 input, 1 output
// - Bank1 polarity bits 0-4: 0 plain, 1 inverted
// - Polarity bits 5-7 store, read back, no effect
// - Bank2 bit 3 sets bank2_pin3 direction
// - Bank2 bit 5 reads zero, writes ignored
// - Bank2 bit 7 puts interrupt on bank1_pin2
// - Non-inverted interrupt function drives active low
// - Open drain selectable for interrupt pin
// - All three registers reset to zero
`timescale 1ns/1ps
module gdpc_gpio_config (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cfg_state_i,
	input wire logic idx_wr_i,
	input wire logic data_wr_i,
	input wire logic data_rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic ack_o,
	output logic hit_o,
	input wire logic smi_req_i,
	input wire logic od_sel_i,
	input wire logic [5:0] gpio_out_val_i,
	input wire logic [5:0] pad_in_i,
	output logic [5:0] pad_out_o,
	output logic [5:0] pad_oe_o,
	output logic [5:0] gpio_in_val_o
);
	logic [7:0] config_index_register;
	logic [7:0] gpio_bank1_direction;
	logic [7:0] gpio_bank1_polarity;
	logic [7:0] gpio_bank2_direction_altfn;
	gdpc_pkg::gdpc_acc_t acc_state;
	gdpc_pkg::gdpc_acc_t next_acc_state;
	logic [5:0] pin_dir;
	logic [5:0] pin_pol;
	logic smi_sel;

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == gdpc_pkg::IDX_BANK1_DIR) ||
			(idx == gdpc_pkg::IDX_BANK1_POL) ||
			(idx == gdpc_pkg::IDX_BANK2_DIR);
	endfunction : is_mapped

	function automatic logic wr_hit(input logic [7:0] idx,
		input logic [7:0] target);
		wr_hit = idx == target;
	endfunction : wr_hit

	// Index is only meaningful inside the configuration state
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			config_index_register <= gdpc_pkg::IDX_RESET;
		end else if (cfg_state_i && idx_wr_i) begin
			config_index_register <= wdata_i;
		end
	end

	wire wr_ok = cfg_state_i && data_wr_i;

	// Reserved high bits kept as written; host restores defaults
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_bank1_direction <= gdpc_pkg::REG_RESET;
		end else if (wr_ok && wr_hit(config_index_register,
			gdpc_pkg::IDX_BANK1_DIR)) begin
			gpio_bank1_direction <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_bank1_polarity <= gdpc_pkg::REG_RESET;
		end else if (wr_ok && wr_hit(config_index_register,
			gdpc_pkg::IDX_BANK1_POL)) begin
			gpio_bank1_polarity <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_bank2_direction_altfn <= gdpc_pkg::REG_RESET;
		end else if (wr_ok && wr_hit(config_index_register,
			gdpc_pkg::IDX_BANK2_DIR)) begin
			gpio_bank2_direction_altfn <= wdata_i &
				gdpc_pkg::BANK2_WR_MASK;
		end
	end

	// Access tracker: one answer cycle per strobe
	always_comb begin
		if (cfg_state_i && data_rd_i) begin
			next_acc_state = gdpc_pkg::ACC_READ;
		end else if (wr_ok) begin
			next_acc_state = gdpc_pkg::ACC_WRITE;
		end else begin
			next_acc_state = gdpc_pkg::ACC_IDLE;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_state <= gdpc_pkg::ACC_IDLE;
		end else begin
			acc_state <= next_acc_state;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			hit_o <= 1'b0;
		end else begin
			ack_o <= next_acc_state != gdpc_pkg::ACC_IDLE;
			hit_o <= (next_acc_state != gdpc_pkg::ACC_IDLE) &&
				is_mapped(config_index_register);
		end
	end

	// Read data held until the next read answer
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= gdpc_pkg::REG_RESET;
		end else if (next_acc_state == gdpc_pkg::ACC_READ) begin
			case (config_index_register)
				gdpc_pkg::IDX_BANK1_DIR: begin
					rdata_o <= gpio_bank1_direction;
				end
				gdpc_pkg::IDX_BANK1_POL: begin
					rdata_o <= gpio_bank1_polarity;
				end
				gdpc_pkg::IDX_BANK2_DIR: begin
					rdata_o <= gpio_bank2_direction_altfn;
				end
				default: begin
					rdata_o <= gdpc_pkg::UNMAPPED_DATA;
				end
			endcase
		end
	end

	// Bank 2 polarity lives elsewhere; that pin stays non-inverted
	assign pin_dir = {gpio_bank2_direction_altfn[gdpc_pkg::BANK2_DIR_BIT],
		gpio_bank1_direction[gdpc_pkg::BANK1_PINS-1:0]};
	assign pin_pol = {1'b0,
		gpio_bank1_polarity[gdpc_pkg::BANK1_PINS-1:0]};
	assign smi_sel =
		gpio_bank2_direction_altfn[gdpc_pkg::BANK2_ALTFN_BIT];

	for (genvar i = 0; i < gdpc_pkg::NUM_PINS; i++) begin : g_pin
		gdpc_pin_cell u_cell (
			.core_clk_i(core_clk_i),
			.rst_n_i(rst_n_i),
			.dir_i(pin_dir[i]),
			.pol_i(pin_pol[i]),
			.alt_en_i(i == gdpc_pkg::SMI_PIN_IDX ? smi_sel : 1'b0),
			.alt_req_i(smi_req_i),
			.od_sel_i(od_sel_i),
			.out_val_i(gpio_out_val_i[i]),
			.pad_in_i(pad_in_i[i]),
			.pad_out_o(pad_out_o[i]),
			.pad_oe_o(pad_oe_o[i]),
			.in_val_o(gpio_in_val_o[i])
		);
	end

	sequence s_cfg_wr(logic [7:0] idx);
		cfg_state_i && data_wr_i && config_index_register == idx;
	endsequence

	sequence s_cfg_rd(logic [7:0] idx);
		cfg_state_i && data_rd_i && config_index_register == idx;
	endsequence

	AST_WR_DIR: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_wr(gdpc_pkg::IDX_BANK1_DIR) |=>
		gpio_bank1_direction == $past(wdata_i))
		else $error("Bank1 direction write lost");

	AST_NO_ACCESS_OUTSIDE: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		!cfg_state_i |=> $stable({gpio_bank1_direction,
		gpio_bank1_polarity, gpio_bank2_direction_altfn}) && !ack_o)
		else $error("Register changed outside config state");

	AST_RO_BIT: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_rd(gdpc_pkg::IDX_BANK2_DIR) |=>
		!rdata_o[gdpc_pkg::BANK2_RO_BIT])
		else $error("Read-only bit read back as one");

	AST_POL_READBACK: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_rd(gdpc_pkg::IDX_BANK1_POL) |=>
		ack_o && hit_o && rdata_o == $past(gpio_bank1_polarity))
		else $error("Polarity value did not read back");

	AST_UNMAPPED: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		cfg_state_i && data_rd_i && !is_mapped(config_index_register)
		|=> ack_o && !hit_o && rdata_o == gdpc_pkg::UNMAPPED_DATA)
		else $error("Foreign index answered");

	AST_DIR_OE: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_wr(gdpc_pkg::IDX_BANK1_DIR) ##1 1'b1 |=>
		pad_oe_o[0] == $past(wdata_i[0], 2))
		else $error("Pin 0 enable does not follow direction");

	AST_BANK2_OE: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		1'b1 |=> pad_oe_o[gdpc_pkg::BANK2_PIN_IDX] ==
		$past(gpio_bank2_direction_altfn[gdpc_pkg::BANK2_DIR_BIT]))
		else $error("Bank2 pin enable does not follow direction");

	AST_SMI_LOW: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		smi_sel && !pin_pol[gdpc_pkg::SMI_PIN_IDX] && smi_req_i &&
		!od_sel_i |=> pad_oe_o[gdpc_pkg::SMI_PIN_IDX] &&
		!pad_out_o[gdpc_pkg::SMI_PIN_IDX])
		else $error("Interrupt not driven low");

	AST_SMI_OD: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		smi_sel && od_sel_i |=> !pad_out_o[gdpc_pkg::SMI_PIN_IDX] &&
		pad_oe_o[gdpc_pkg::SMI_PIN_IDX] == $past(smi_req_i !=
		pin_pol[gdpc_pkg::SMI_PIN_IDX]))
		else $error("Open drain interrupt drives high");

	AST_INV_IN: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		1'b1 |=> gpio_in_val_o[1] == $past(pad_in_i[1] ^ pin_pol[1]))
		else $error("Input polarity not applied");

	AST_INV_OUT: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		1'b1 |=> pad_out_o[0] == $past(gpio_out_val_i[0] ^ pin_pol[0]))
		else $error("Output polarity not applied");

	AST_WR_POL: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_wr(gdpc_pkg::IDX_BANK1_POL) |=>
		gpio_bank1_polarity == $past(wdata_i))
		else $error("Bank1 polarity write lost");

	AST_WR_BANK2: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_wr(gdpc_pkg::IDX_BANK2_DIR) |=>
		gpio_bank2_direction_altfn[gdpc_pkg::BANK2_DIR_BIT] ==
		$past(wdata_i[gdpc_pkg::BANK2_DIR_BIT]))
		else $error("Bank2 direction write lost");

	AST_WR_ALTFN: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_wr(gdpc_pkg::IDX_BANK2_DIR) |=>
		gpio_bank2_direction_altfn[gdpc_pkg::BANK2_ALTFN_BIT] ==
		$past(wdata_i[gdpc_pkg::BANK2_ALTFN_BIT]))
		else $error("Function select write lost");

	AST_IDX_LOAD: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		cfg_state_i && idx_wr_i |=>
		config_index_register == $past(wdata_i))
		else $error("Index write lost");

	AST_IDX_REFUSED: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		!cfg_state_i |=> $stable(config_index_register))
		else $error("Index changed outside config state");

	AST_ACK_REQ: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		cfg_state_i && (data_wr_i || data_rd_i) |=>
		ack_o && acc_state != gdpc_pkg::ACC_IDLE)
		else $error("Data access not answered");

	AST_HIT_ACK: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		hit_o |-> ack_o)
		else $error("Hit shown without answer");

	AST_RD_DIR: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		s_cfg_rd(gdpc_pkg::IDX_BANK1_DIR) |=>
		ack_o && hit_o && rdata_o == $past(gpio_bank1_direction))
		else $error("Direction value did not read back");

	AST_SMI_OE: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		smi_sel && !od_sel_i |=> pad_oe_o[gdpc_pkg::SMI_PIN_IDX])
		else $error("Interrupt pin not driven");

	AST_GPIO_PIN2: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		!smi_sel |=> pad_oe_o[gdpc_pkg::SMI_PIN_IDX] ==
		$past(pin_dir[gdpc_pkg::SMI_PIN_IDX]))
		else $error("Pin 2 enable does not follow direction");

	AST_SMI_HIGH: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		smi_sel && !pin_pol[gdpc_pkg::SMI_PIN_IDX] && !smi_req_i &&
		!od_sel_i |=> pad_oe_o[gdpc_pkg::SMI_PIN_IDX] &&
		pad_out_o[gdpc_pkg::SMI_PIN_IDX])
		else $error("Idle interrupt not driven high");

	AST_BANK2_NOINV: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		1'b1 |=> gpio_in_val_o[gdpc_pkg::BANK2_PIN_IDX] ==
		$past(pad_in_i[gdpc_pkg::BANK2_PIN_IDX]))
		else $error("Bank2 input inverted");
endmodule : gdpc_gpio_config

// File: logic/gdpc_pkg.sv
package gdpc_pkg;
	// Configuration indices of the three registers
	localparam logic [7:0] IDX_BANK1_DIR = 8'h31;
	localparam logic [7:0] IDX_BANK1_POL = 8'h32;
	localparam logic [7:0] IDX_BANK2_DIR = 8'h33;
	localparam logic [7:0] IDX_RESET = 8'h00;

	// Reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;
	// Value returned for an index this block does not own
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// Bank 2 register: bit 5 reads zero, writes ignored
	localparam logic [7:0] BANK2_WR_MASK = 8'hdf;
	localparam int BANK2_DIR_BIT = 3;
	localparam int BANK2_RO_BIT = 5;
	localparam int BANK2_ALTFN_BIT = 7;

	// Pin map: bank 1 pins 0..4, then bank 2 pin 3
	localparam int BANK1_PINS = 5;
	localparam int NUM_PINS = 6;
	localparam int BANK2_PIN_IDX = 5;
	localparam int SMI_PIN_IDX = 2;

	// Register access tracker
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_READ = 2'b01,
		ACC_WRITE = 2'b10
	} gdpc_acc_t;
endpackage : gdpc_pkg

// File: logic/gdpc_pin_cell.sv
`timescale 1ns/1ps
module gdpc_pin_cell (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic dir_i,
	input wire logic pol_i,
	input wire logic alt_en_i,
	input wire logic alt_req_i,
	input wire logic od_sel_i,
	input wire logic out_val_i,
	input wire logic pad_in_i,
	output logic pad_out_o,
	output logic pad_oe_o,
	output logic in_val_o
);
	logic level;

	// Level on the pin before the driver type is applied
	always_comb begin
		if (alt_en_i) begin
			// Non-inverted polarity gives an active-low request
			level = pol_i ? alt_req_i : ~alt_req_i;
		end else begin
			level = out_val_i ^ pol_i;
		end
	end

	// Registered driver so pins never glitch on a register write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_out_o <= 1'b0;
			pad_oe_o <= 1'b0;
		end else if (alt_en_i && od_sel_i) begin
			// Open drain: only pull low, release for high
			pad_out_o <= 1'b0;
			pad_oe_o <= ~level;
		end else if (alt_en_i) begin
			pad_out_o <= level;
			pad_oe_o <= 1'b1;
		end else begin
			pad_out_o <= level;
			pad_oe_o <= dir_i;
		end
	end

	// Read-back path is inverted by the same polarity bit
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_val_o <= 1'b0;
		end else begin
			in_val_o <= pad_in_i ^ pol_i;
		end
	end
endmodule : gdpc_pin_cell

// File: tb/gdpc_host_model.sv
`timescale 1ns/1ps
module gdpc_host_model (
	input wire logic core_clk_i,
	input wire logic ack_i,
	input wire logic hit_i,
	input wire logic [7:0] rdata_i,
	output logic cfg_state_o,
	output logic idx_wr_o,
	output logic data_wr_o,
	output logic data_rd_o,
	output logic [7:0] wdata_o
);
	initial begin
		cfg_state_o = 1'b0;
		idx_wr_o = 1'b0;
		data_wr_o = 1'b0;
		data_rd_o = 1'b0;
		wdata_o = 8'h00;
	end

	// Index cycle, then one data cycle; data lines show junk when idle
	task automatic xfer(input logic cfg, input logic wr,
		input logic [7:0] idx, input logic [7:0] val,
		output logic ack, output logic hit, output logic [7:0] data);
		@(posedge core_clk_i);
		cfg_state_o <= cfg;
		idx_wr_o <= 1'b1;
		wdata_o <= idx;
		@(posedge core_clk_i);
		idx_wr_o <= 1'b0;
		data_wr_o <= wr;
		data_rd_o <= ~wr;
		wdata_o <= val;
		@(posedge core_clk_i);
		data_wr_o <= 1'b0;
		data_rd_o <= 1'b0;
		wdata_o <= ~val;
		cfg_state_o <= 1'b0;
		#1;
		ack = ack_i;
		hit = hit_i;
		data = rdata_i;
	endtask : xfer
endmodule : gdpc_host_model

// File: tb/gdpc_gpio_config_tb.sv
`timescale 1ns/1ps
module gdpc_gpio_config_tb;
	logic clk, rst_n, smi_req, od_sel, cfg, iw, dw, dr, ack, hit, ack_w, hit_w;
	logic [7:0] wd, rd, rdata;
	logic [5:0] gout, pin, pad_out, pad_oe, in_val;
	logic [7:0] v [3];
	logic [7:0] idx_tab [3];
	logic [17:0] e;
	integer num_errors, comparisons, cycles, seed;

	gdpc_gpio_config gdpc_gpio_config_i (.core_clk_i(clk), .rst_n_i(rst_n),
		.cfg_state_i(cfg), .idx_wr_i(iw), .data_wr_i(dw), .data_rd_i(dr),
		.wdata_i(wd), .rdata_o(rdata), .ack_o(ack_w), .hit_o(hit_w),
		.smi_req_i(smi_req), .od_sel_i(od_sel), .gpio_out_val_i(gout),
		.pad_in_i(pin), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
		.gpio_in_val_o(in_val));
	gdpc_host_model gdpc_host_model_i (.core_clk_i(clk), .ack_i(ack_w),
		.hit_i(hit_w), .rdata_i(rdata), .cfg_state_o(cfg), .idx_wr_o(iw),
		.data_wr_o(dw), .data_rd_o(dr), .wdata_o(wd));

	always #4 clk = ~clk;

	task automatic check(input string name, input logic [7:0] seen, exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task test_done();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// Expected {oe, out, in}; bank 2 pin has no polarity bit here
	function automatic logic [17:0] exp_pads(input logic [7:0] d1, pl, d3,
		input logic [5:0] ov, pi, input logic smi, od);
		logic [5:0] oe, po, iv;
		logic p, lvl;
		for (int k = 0; k < 6; k++) begin
			p = (k < 5) ? pl[k] : 1'b0;
			oe[k] = (k < 5) ? d1[k] : d3[3];
			po[k] = ov[k] ^ p;
			iv[k] = pi[k] ^ p;
		end
		lvl = pl[2] ? smi : ~smi;
		if (d3[7]) begin
			oe[2] = od ? ~lvl : 1'b1;
			po[2] = od ? 1'b0 : lvl;
		end
		return {oe, po, iv};
	endfunction : exp_pads

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			test_done();
		end
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		smi_req = 1'b0;
		od_sel = 1'b0;
		gout = 6'h00;
		pin = 6'h00;
		num_errors = 0;
		comparisons = 0;
		cycles = 0;
		seed = 32'h43a23440;
		idx_tab[0] = gdpc_pkg::IDX_BANK1_DIR;
		idx_tab[1] = gdpc_pkg::IDX_BANK1_POL;
		idx_tab[2] = gdpc_pkg::IDX_BANK2_DIR;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			gdpc_host_model_i.xfer(1'b1, 1'b0, idx_tab[k], 8'h00, ack, hit, rd);
			check("reset_value", rd, 8'h00);
			check("hit", {6'h00, ack, hit}, 8'h03);
		end
		for (int i = 0; i < 40; i++) begin
			// First pass sets direction bits 0-4, all polarity bits and bank 2 bits 3, 5, 7 to catch stuck bits
			v[0] = (i == 0) ? 8'h1f : 8'($random(seed)) & 8'h1f;
			v[1] = (i == 0) ? 8'hff : 8'($random(seed));
			v[2] = (i == 0) ? 8'ha8 : 8'($random(seed)) & 8'ha8;
			for (int k = 0; k < 3; k++) begin
				gdpc_host_model_i.xfer(1'b1, 1'b1, idx_tab[k], v[k], ack, hit, rd);
			end
			for (int k = 0; k < 3; k++) begin
				gdpc_host_model_i.xfer(1'b1, 1'b0, idx_tab[k], 8'h00, ack, hit, rd);
				check("readback", rd, v[k] & ((k == 2) ? 8'hdf : 8'hff));
			end
			@(posedge clk);
			gout <= 6'($random(seed));
			pin <= 6'($random(seed));
			smi_req <= 1'($random(seed));
			od_sel <= 1'($random(seed));
			repeat (3) @(posedge clk);
			#1;
			e = exp_pads(v[0], v[1], v[2], gout, pin, smi_req, od_sel);
			check("pad_oe", {2'b00, pad_oe}, {2'b00, e[17:12]});
			check("pad_out", {2'b00, pad_out}, {2'b00, e[11:6]});
			check("in_val", {2'b00, in_val}, {2'b00, e[5:0]});
		end
		gdpc_host_model_i.xfer(1'b0, 1'b1, idx_tab[1], ~v[1], ack, hit, rd);
		check("refused_ack", {7'h00, ack}, 8'h00);
		gdpc_host_model_i.xfer(1'b1, 1'b0, idx_tab[1], 8'h00, ack, hit, rd);
		check("refused_keep", rd, v[1]);
		gdpc_host_model_i.xfer(1'b1, 1'b1, 8'h34, 8'h5a, ack, hit, rd);
		gdpc_host_model_i.xfer(1'b1, 1'b0, 8'h34, 8'h00, ack, hit, rd);
		check("unmapped", {rd[5:0], ack, hit}, 8'h02);
		test_done();
	end
endmodule : gdpc_gpio_config_tb
